// *** imp_unit.v ***
// integer multiply unit with parallel add, subtract and store forms
// assumes an Avalon-MM master on clk_sys; one command executes per command write
//
// Function
// RULE1 - operands are 24-bit signed, product 48-bit, low 32 bits written
// RULE2 - overflow when any top 16 product bits differ from result sign bit
// RULE3 - flags change only when the multiply destination is register 0 to 7
// RULE4 - sticky overflow set on overflow else kept; float underflow and carry kept
// RULE5 - overflow flag equals overflow; underflow flag cleared
// RULE6 - single and store forms: negative and zero flags follow written result
// RULE7 - a multiply result depends on the saturate mode bit only when the product overflows
// RULE8 - three-operand mode field selects register or indirect per operand; regs 0-27
// RULE9 - indirect displacement is 0, 1, index register zero or one
// RULE10 - parallel forms read all registers before either operation writes
// RULE11 - store form: indirect source fetched before the store is written
// RULE12 - multiply-add pairing field selects multiply and add operand fields
// RULE13 - multiply-subtract uses same pairing; first-listed minus second-listed
// RULE14 - software supplies two indirect and two register sources in add/sub forms
// RULE15 - store form multiplies into register and stores register 0-7 to memory
// RULE16 - saturate mode with overflow clamps to largest value of product sign
// RULE17 - one bit picks product register 0/1, another sum register 2/3
// RULE18 - each form completes in one execute cycle
`timescale 1ns/100ps
`include "imp_defines.vh"

module imp_unit #(
  parameter MEM_DEPTH = 16,
  parameter MEM_AW = 4
) (
  input wire clk_sys,
  input wire resetn,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg irq
);
  reg [31:0] regs [0:27];
  reg [31:0] mem [0:MEM_DEPTH-1];
  reg [31:0] cmd;
  reg execPend;
  reg [7:0] flags;
  reg [1:0] irqStatus;
  reg [1:0] irqMask;

  reg [31:0] mulA;
  reg [31:0] mulB;
  reg [4:0] mulDst;
  reg mulValid;
  reg [31:0] arA;
  reg [31:0] arB;
  reg arSub;
  reg arValid;
  reg [4:0] arDst;
  reg stValid;
  reg [MEM_AW-1:0] stAddr;
  reg [31:0] stData;
  reg nzFromResult;
  reg [31:0] rdMux;
  reg [1:0] next_irqStatus;
  integer i;

  wire [31:0] mulRes;
  wire mulOvf;
  wire [31:0] arRes;
  wire arOvf;
  wire ovfAny;
  wire updFlags;
  wire busWr;
  wire [1:0] region;
  wire [7:0] wordIdx;
  wire [4:0] slotIdx;
  wire regHit;
  wire memHit;
  wire [2:0] op;
  wire [1:0] mode;
  wire [4:0] fDst;
  wire [4:0] f1;
  wire [4:0] f2;
  wire [4:0] f3;
  wire [4:0] f4;

  assign op = cmd[`IMP_CMD_OP];
  assign mode = cmd[`IMP_CMD_MODE];
  assign fDst = cmd[`IMP_CMD_DST];
  assign f1 = cmd[`IMP_CMD_F1];
  assign f2 = cmd[`IMP_CMD_F2];
  assign f3 = cmd[`IMP_CMD_F3];
  assign f4 = cmd[`IMP_CMD_F4];

  assign busWr = avs_write & ~avs_waitrequest;
  assign region = avs_address[9:8];
  assign wordIdx = avs_address[9:2];
  assign slotIdx = avs_address[6:2];
  assign regHit = (region == `IMP_REGION_REGS) && (slotIdx < `IMP_NUM_REGS)
                  && (avs_address[7] == 1'b0);
  assign memHit = (region == `IMP_REGION_MEM) && ({1'b0, slotIdx} < MEM_DEPTH)
                  && (avs_address[7] == 1'b0);

  // registers 28 to 31 do not exist and read as zero
  function [31:0] rdReg;
    input [4:0] idx;
    begin
      rdReg = (idx < `IMP_NUM_REGS) ? regs[idx] : 32'h0000_0000; // RULE8
    end
  endfunction

  // descriptor: [2:0] selects an address register, [4:3] the displacement
  function [MEM_AW-1:0] indAddr;
    input [4:0] desc;
    reg [31:0] base;
    reg [31:0] disp;
    reg [31:0] sum;
    begin
      base = regs[`IMP_AUX_BASE + {2'b00, desc[2:0]}];
      case (desc[4:3])
        `IMP_DISP_ZERO: disp = 32'h0000_0000; // RULE9
        `IMP_DISP_ONE: disp = 32'h0000_0001; // RULE9
        `IMP_DISP_IDX0: disp = regs[`IMP_IDX0_REG]; // RULE9
        default: disp = regs[`IMP_IDX1_REG]; // RULE9
      endcase
      sum = base + disp;
      indAddr = sum[MEM_AW-1:0];
    end
  endfunction

  function [31:0] operand;
    input [4:0] field;
    input isInd;
    begin
      operand = isInd ? mem[indAddr(field)] : rdReg(field);
    end
  endfunction

  function [31:0] byteMerge;
    input [31:0] old;
    input [31:0] upd;
    input [3:0] be;
    integer k;
    begin
      byteMerge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          byteMerge[8*k +: 8] = upd[8*k +: 8];
        end
      end
    end
  endfunction

  imp_mul_core u_mul (
    .opA(mulA),
    .opB(mulB),
    .satMode(flags[`IMP_FLG_SAT]),
    .result(mulRes),
    .overflow(mulOvf)
  );

  // operand routing; every read sees the state before this cycle's writes
  always @* begin
    mulA = 32'h0000_0000;
    mulB = 32'h0000_0000;
    mulDst = 5'h00;
    mulValid = 1'b0;
    arA = 32'h0000_0000;
    arB = 32'h0000_0000;
    arSub = 1'b0;
    arValid = 1'b0;
    arDst = `IMP_SUM_BASE + {4'h0, cmd[`IMP_CMD_D2]}; // RULE17
    stValid = 1'b0;
    stAddr = indAddr(f4);
    stData = rdReg({2'b00, f3[2:0]}); // RULE15
    nzFromResult = 1'b1;
    case (op)
      `IMP_OP_MUL2: begin
        mulA = rdReg(fDst);
        mulB = operand(f1, mode[1]);
        mulDst = fDst;
        mulValid = 1'b1;
      end
      `IMP_OP_MUL3: begin
        mulA = operand(f1, mode[0]); // RULE8
        mulB = operand(f2, mode[1]); // RULE8
        mulDst = fDst;
        mulValid = 1'b1;
      end
      `IMP_OP_MULADD, `IMP_OP_MULSUB: begin
        // src1, src2 are registers, src3, src4 indirect by encoding
        mulValid = 1'b1;
        arValid = 1'b1;
        arSub = (op == `IMP_OP_MULSUB);
        nzFromResult = 1'b0;
        mulDst = {4'h0, cmd[`IMP_CMD_D1]}; // RULE17
        case (mode)
          2'b00: begin
            mulA = mem[indAddr(f3)]; // RULE12
            mulB = mem[indAddr(f4)];
            arA = rdReg(f1); // RULE13
            arB = rdReg(f2);
          end
          2'b01: begin
            mulA = mem[indAddr(f3)]; // RULE12
            mulB = rdReg(f1);
            arA = mem[indAddr(f4)]; // RULE13
            arB = rdReg(f2);
          end
          2'b10: begin
            mulA = rdReg(f1); // RULE12
            mulB = rdReg(f2);
            arA = mem[indAddr(f3)]; // RULE13
            arB = mem[indAddr(f4)];
          end
          default: begin
            mulA = mem[indAddr(f3)]; // RULE12
            mulB = rdReg(f1);
            arA = rdReg(f2); // RULE13
            arB = mem[indAddr(f4)];
          end
        endcase
      end
      `IMP_OP_MULSTORE: begin
        mulA = rdReg({2'b00, f1[2:0]});
        mulB = mem[indAddr(f2)]; // RULE11
        mulDst = {2'b00, fDst[2:0]}; // RULE15
        mulValid = 1'b1;
        stValid = 1'b1; // RULE15
      end
      default: begin
        mulValid = 1'b0;
      end
    endcase
    // array reads inside functions are invisible to @*; execPend wakes it
    if (!execPend) begin
      mulValid = 1'b0;
      arValid = 1'b0;
      stValid = 1'b0;
    end
  end

  assign arRes = arSub ? (arA - arB) : (arA + arB);
  assign arOvf = arValid & (arSub ? ((arA[31] != arB[31]) && (arRes[31] != arA[31]))
                                  : ((arA[31] == arB[31]) && (arRes[31] != arA[31])));
  assign ovfAny = mulOvf | arOvf;
  assign updFlags = execPend & mulValid & (mulDst < `IMP_EXT_REGS); // RULE3

  always @* begin
    rdMux = 32'h0000_0000;
    if (region == `IMP_REGION_CTRL) begin
      case (wordIdx)
        `IMP_OFF_CMD: rdMux = cmd;
        `IMP_OFF_FLAGS: rdMux = {24'h00_0000, flags};
        `IMP_OFF_IRQ_STATUS: rdMux = {30'h0000_0000, irqStatus};
        `IMP_OFF_IRQ_MASK: rdMux = {30'h0000_0000, irqMask};
        default: rdMux = 32'h0000_0000;
      endcase
    end else if (regHit) begin
      rdMux = regs[slotIdx];
    end else if (memHit) begin
      rdMux = mem[slotIdx[MEM_AW-1:0]];
    end
  end

  // events win over a same-cycle write-one-to-clear
  always @* begin
    next_irqStatus = irqStatus;
    if (busWr && (region == `IMP_REGION_CTRL) && (wordIdx == `IMP_OFF_IRQ_STATUS)
        && avs_byteenable[0]) begin
      next_irqStatus = irqStatus & ~avs_writedata[1:0];
    end
    if (execPend) begin
      next_irqStatus[`IMP_IRQ_DONE] = 1'b1;
    end
    if (execPend && mulValid && ovfAny) begin
      next_irqStatus[`IMP_IRQ_OVF] = 1'b1;
    end
  end

  // one wait state on every access; readdata is loaded with the acknowledge
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      irqStatus <= `IMP_IRQ_RESET;
      irqMask <= `IMP_IRQ_RESET;
      irq <= 1'b0;
    end else begin
      if ((avs_read | avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        if (avs_read) begin
          avs_readdata <= rdMux;
        end
      end else begin
        avs_waitrequest <= 1'b1;
      end
      irqStatus <= next_irqStatus;
      if (busWr && (region == `IMP_REGION_CTRL) && (wordIdx == `IMP_OFF_IRQ_MASK)
          && avs_byteenable[0]) begin
        irqMask <= avs_writedata[1:0];
      end
      irq <= |(irqStatus & irqMask);
    end
  end

  // a bus write and an execute never share an edge: the command write
  // is acknowledged, execute follows, and the next write needs a wait state
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmd <= `IMP_CMD_RESET;
      execPend <= 1'b0;
      flags <= `IMP_FLAGS_RESET;
      for (i = 0; i < 28; i = i + 1) begin
        regs[i] <= 32'h0000_0000;
      end
      for (i = 0; i < MEM_DEPTH; i = i + 1) begin
        mem[i] <= 32'h0000_0000;
      end
    end else begin
      execPend <= 1'b0;
      if (busWr) begin
        if (region == `IMP_REGION_CTRL && wordIdx == `IMP_OFF_CMD) begin
          cmd <= byteMerge(cmd, avs_writedata, avs_byteenable);
          execPend <= 1'b1;
        end
        if (region == `IMP_REGION_CTRL && wordIdx == `IMP_OFF_FLAGS
            && avs_byteenable[0]) begin
          flags <= avs_writedata[7:0];
        end
        if (regHit) begin
          regs[slotIdx] <= byteMerge(regs[slotIdx], avs_writedata, avs_byteenable);
        end
        if (memHit) begin
          mem[slotIdx[MEM_AW-1:0]] <= byteMerge(mem[slotIdx[MEM_AW-1:0]],
                                                avs_writedata, avs_byteenable);
        end
      end
      if (execPend) begin
        // all writes of the command land on this one edge
        if (mulValid && mulDst < `IMP_NUM_REGS) begin
          regs[mulDst] <= mulRes; // RULE18
        end
        if (arValid) begin
          regs[arDst] <= arRes; // RULE10
        end
        if (stValid) begin
          mem[stAddr] <= stData; // RULE11
        end
        if (updFlags) begin
          flags[`IMP_FLG_LV] <= flags[`IMP_FLG_LV] | ovfAny; // RULE4
          flags[`IMP_FLG_V] <= ovfAny; // RULE5
          flags[`IMP_FLG_UF] <= 1'b0; // RULE5
          flags[`IMP_FLG_N] <= nzFromResult & mulRes[31]; // RULE6
          flags[`IMP_FLG_Z] <= nzFromResult & (mulRes == 32'h0000_0000); // RULE6
        end
      end
    end
  end
endmodule

// *** imp_defines.vh ***
// constants of the integer multiply unit: register map, command fields, flag bits
// assumes inclusion by the unit's design files only
`ifndef IMP_DEFINES_VH
`define IMP_DEFINES_VH

// word offsets (byte address bits [9:2]) of the control registers
`define IMP_OFF_CMD 8'h00
`define IMP_OFF_FLAGS 8'h01
`define IMP_OFF_IRQ_STATUS 8'h02
`define IMP_OFF_IRQ_MASK 8'h03
// region select in byte address bits [9:8]
`define IMP_REGION_CTRL 2'h0
`define IMP_REGION_REGS 2'h1
`define IMP_REGION_MEM 2'h2

`define IMP_NUM_REGS 5'h1C
`define IMP_EXT_REGS 5'h08
`define IMP_AUX_BASE 5'h08
`define IMP_IDX0_REG 5'h10
`define IMP_IDX1_REG 5'h11
`define IMP_SUM_BASE 5'h02

// command word fields
`define IMP_CMD_OP 2:0
`define IMP_CMD_MODE 4:3
`define IMP_CMD_D1 5
`define IMP_CMD_D2 6
`define IMP_CMD_DST 11:7
`define IMP_CMD_F1 16:12
`define IMP_CMD_F2 21:17
`define IMP_CMD_F3 26:22
`define IMP_CMD_F4 31:27
`define IMP_CMD_RESET 32'h0000_0000

// operation codes
`define IMP_OP_MUL2 3'h0
`define IMP_OP_MUL3 3'h1
`define IMP_OP_MULADD 3'h2
`define IMP_OP_MULSUB 3'h3
`define IMP_OP_MULSTORE 3'h4

// displacement select of an indirect descriptor
`define IMP_DISP_ZERO 2'h0
`define IMP_DISP_ONE 2'h1
`define IMP_DISP_IDX0 2'h2

// flag register bits
`define IMP_FLG_C 0
`define IMP_FLG_V 1
`define IMP_FLG_Z 2
`define IMP_FLG_N 3
`define IMP_FLG_UF 4
`define IMP_FLG_LV 5
`define IMP_FLG_LUF 6
`define IMP_FLG_SAT 7
`define IMP_FLAGS_RESET 8'h00

// interrupt bits
`define IMP_IRQ_DONE 0
`define IMP_IRQ_OVF 1
`define IMP_IRQ_RESET 2'h0

`define IMP_SAT_POS 32'h7FFF_FFFF
`define IMP_SAT_NEG 32'h8000_0000

`endif

// *** imp_mul_core.v ***
// 24 by 24 signed multiplier with truncation, overflow and saturation
// assumes operands held stable for the execute cycle; purely combinational
`timescale 1ns/100ps
`include "imp_defines.vh"

module imp_mul_core (
  input wire [31:0] opA,
  input wire [31:0] opB,
  input wire satMode,
  output wire [31:0] result,
  output wire overflow
);
  wire signed [23:0] narrowA;
  wire signed [23:0] narrowB;
  wire signed [47:0] product;
  wire sat;

  // upper operand bits are ignored by design
  assign narrowA = opA[23:0]; // RULE1
  assign narrowB = opB[23:0]; // RULE1
  assign product = narrowA * narrowB; // RULE1
  assign overflow = (product[47:32] != {16{product[31]}}); // RULE2
  assign sat = satMode & overflow; // RULE7
  // clamp follows the true product sign, not the truncated word
  assign result = sat ? (product[47] ? `IMP_SAT_NEG : `IMP_SAT_POS) // RULE16
                      : product[31:0]; // RULE1
endmodule

// *** imp_unit_chk.sv ***
// checker of the multiply unit's register bus and interrupt line
// assumes binding to imp_unit, seeing only its ports
`timescale 1ns/100ps
module imp_unit_chk (
  input wire clk_sys,
  input wire resetn,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire irq
);
  wire wrAck = avs_write && !avs_waitrequest;
  wire cmdAck = wrAck && avs_address[9:2] == 8'h00;
  wire maskAck = wrAck && avs_address[9:2] == 8'h03 && avs_byteenable[0];
  wire [1:0] rgn = avs_address[9:8];
  wire [5:0] ofs = avs_address[7:2];
  // spare control words, registers past 27 and the top region
  wire hole = (rgn == 2'h0 && ofs > 6'h03) || (rgn == 2'h1 && ofs > 6'h1B) || rgn == 2'h3;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  sequence s_clear;
    wrAck && ofs == 6'h02 && rgn == 2'h0 && avs_byteenable[0] && avs_writedata[1:0] == 2'h3;
  endsequence
  a_wait_answer: assert property (s_req |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  a_wait_single: assert property (s_ack |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_ack_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("acknowledge without request");
  a_unmapped_zero: assert property (
    avs_read && !avs_waitrequest && hole |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
    else $error("read data moved outside a read");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(cmdAck, 3) || $past(maskAck, 2))
    else $error("irq rose without cause");
  a_mask_quiet: assert property (
    maskAck && avs_writedata[1:0] == 2'h0 |=> ##1 !irq [*2])
    else $error("irq high while masked");
  a_clear_quiet: assert property (s_clear |=> ##1 !irq)
    else $error("irq high after clear");
endmodule

// *** imp_bus_master.sv ***
// bus master standing in for the core side of the multiply unit
// assumes an Avalon-MM slave with waitrequest on clk_sys
`timescale 1ns/100ps
module imp_bus_master (
  input wire clk_sys,
  input wire avs_waitrequest,
  input wire [31:0] avs_readdata,
  output logic [9:0] avs_address = 10'h000,
  output logic avs_read = 1'b0,
  output logic avs_write = 1'b0,
  output logic [31:0] avs_writedata = 32'h0000_0000,
  output logic [3:0] avs_byteenable = 4'hF
);
  task automatic xfer(input logic wr, input logic [9:0] ad, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= ad;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released data must not keep looking valid
    avs_writedata <= ~d;
  endtask
endmodule

// *** imp_unit_tb_top.sv ***
// self-checking bench of the integer multiply unit
// assumes imp_unit, imp_bus_master and imp_unit_chk compiled first
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module imp_unit_tb_top;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  wire [9:0] avs_address;
  wire avs_read;
  wire avs_write;
  wire [31:0] avs_writedata;
  wire [3:0] avs_byteenable;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire irq;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int mA [4] = '{3, 3, 1, 3};
  int mB [4] = '{4, 1, 2, 1};
  int sA [4] = '{1, 4, 3, 2};
  int sB [4] = '{2, 2, 4, 4};
  logic [31:0] q, a, b, r;
  logic [31:0] v [1:4];
  logic [32:0] m, s;
  logic [7:0] fl;
  logic ov;
  logic [4:0] dst;
  logic [1:0] md, dd, k;

  imp_unit u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  imp_bus_master u_bm (
    .clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));

  always #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  function automatic logic [32:0] emul(input logic [31:0] x, y, input logic sat);
    logic signed [47:0] p;
    logic ov;
    p = $signed(x[23:0]) * $signed(y[23:0]);
    ov = p[47:32] != {16{p[31]}};
    if (sat && ov)
      return {ov, p[47] ? 32'h8000_0000 : 32'h7FFF_FFFF};
    return {ov, p[31:0]};
  endfunction

  // flags after a single or store form writing a low register
  function automatic logic [7:0] eflg(input logic [7:0] f, input logic [32:0] e);
    return {f[7:6], f[5] | e[32], 1'b0, e[31], e[31:0] == 32'h0000_0000,
      e[32], f[0]};
  endfunction

  task automatic wr(input logic [9:0] ad, input logic [31:0] d);
    u_bm.xfer(1'b1, ad, d, q);
  endtask
  task automatic rd(input logic [9:0] ad);
    u_bm.xfer(1'b0, ad, 32'h0000_0000, q);
  endtask
  task automatic setr(input int n, input logic [31:0] d);
    wr(10'h100 + 10'(4 * n), d);
  endtask
  task automatic getr(input int n);
    rd(10'h100 + 10'(4 * n));
  endtask
  task automatic run(input logic [2:0] op, input logic [1:0] mo, input logic [1:0] de,
    input logic [4:0] ds, f1, f2, f3, f4);
    wr(10'h000, {f4, f3, f2, f1, ds, de, mo, op});
  endtask

  task automatic close_out();
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    q = $urandom(32'h226f);
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      rd(10'(4 * i));
      `CHK(q, 32'h0000_0000)
    end
    setr(28, 32'hFFFF_FFFF);
    getr(28);
    `CHK(q, 32'h0000_0000)
    setr(1, 32'h0033_C251);
    setr(5, 32'h0078_B600);
    wr(10'h004, 32'h0000_0000);
    run(3'h0, 2'h0, 2'h0, 5'h05, 5'h01, 5'h00, 5'h00, 5'h00);
    m = emul(32'h0078_B600, 32'h0033_C251, 1'b0);
    getr(5);
    `CHK(q, m[31:0])
    rd(10'h004);
    `CHK(q[7:0], eflg(8'h00, m))
    // address registers 8, 9 and both index registers give word 1 or 2
    setr(8, 32'h0000_0000);
    setr(9, 32'h0000_0001);
    setr(16, 32'h0000_0001);
    setr(17, 32'h0000_0001);
    repeat (24) begin
      a = $urandom;
      b = $urandom;
      if (a[0])
        a = {{20{a[11]}}, a[11:0]};
      if (b[1:0] == 2'h0)
        b = 32'h0000_0000;
      fl = 8'($urandom);
      md = 2'($urandom);
      k = 2'(1 + $urandom_range(2));
      dst = $urandom_range(1) ? 5'(3 + $urandom_range(4)) : 5'(10 + $urandom_range(5));
      setr(1, a);
      setr(2, b);
      wr(10'h204, a);
      wr(10'h208, b);
      wr(10'h004, {24'h00_0000, fl});
      run(3'h1, md, 2'h0, dst, md[0] ? {k, 3'h0} : 5'h01, md[1] ? {k, 3'h1} : 5'h02,
        5'h00, 5'h00);
      m = emul(a, b, fl[7]);
      getr(dst);
      `CHK(q, m[31:0])
      rd(10'h004);
      `CHK(q[7:0], dst < 5'h08 ? eflg(fl, m) : fl)
    end
    for (int op = 2; op < 4; op++) begin
      for (int p = 0; p < 4; p++) begin
        foreach (v[j])
          v[j] = $urandom;
        dd = 2'($urandom);
        fl = 8'($urandom);
        setr(1, v[1]);
        setr(3, v[2]);
        wr(10'h200, v[3]);
        wr(10'h208, v[4]);
        wr(10'h004, {24'h00_0000, fl});
        run(3'(op), 2'(p), dd, 5'h00, 5'h01, 5'h03, 5'h00, 5'h09);
        m = emul(v[mA[p]], v[mB[p]], fl[7]);
        s = (op == 2) ? v[sA[p]] + v[sB[p]] : v[sA[p]] - v[sB[p]];
        getr(dd[0]);
        `CHK(q, m[31:0])
        getr(2 + dd[1]);
        `CHK(q, s[31:0])
        ov = m[32] | ((s[31] != v[sA[p]][31]) && ((v[sA[p]][31] == v[sB[p]][31]) == (op == 2)));
        rd(10'h004);
        `CHK(q[7:0], {fl[7:6], fl[5] | ov, 3'h0, ov, fl[0]})
      end
    end
    for (int i = 0; i < 2; i++) begin
      a = $urandom;
      b = i ? 32'h0000_0000 : $urandom;
      r = $urandom;
      setr(1, a);
      setr(6, r);
      wr(10'h200, b);
      wr(10'h004, 32'h0000_0000);
      run(3'h4, 2'h0, 2'h0, 5'h06, 5'h01, 5'h00, 5'h06, 5'h00);
      m = emul(a, b, 1'b0);
      getr(6);
      `CHK(q, m[31:0])
      rd(10'h200);
      `CHK(q, r)
      rd(10'h004);
      `CHK(q[7:0], eflg(8'h00, m))
    end
    wr(10'h00C, 32'h0000_0003);
    rd(10'h008);
    `CHK(q[0], 1'b1)
    `CHK(q[1], 1'b1)
    `CHK(irq, 1'b1)
    wr(10'h008, 32'h0000_0003);
    rd(10'h008);
    `CHK(q[1:0], 2'h0)
    `CHK(irq, 1'b0)
    wr(10'h00C, 32'h0000_0000);
    run(3'h7, 2'h0, 2'h0, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00);
    rd(10'h008);
    `CHK(q[0], 1'b1)
    `CHK(irq, 1'b0)
    wr(10'h00C, 32'h0000_0001);
    rd(10'h00C);
    `CHK(q[1:0], 2'h1)
    `CHK(irq, 1'b1)
    close_out();
  end
endmodule

bind imp_unit imp_unit_chk u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq));
